// ---- temp_limit_regs.svh ----
`ifndef TEMP_LIMIT_REGS_SVH
`define TEMP_LIMIT_REGS_SVH

// command codes of the limit and response registers
`define TL_OT_WARN_CODE 8'h51
`define TL_UT_WARN_CODE 8'h52
`define TL_UT_FAULT_CODE 8'h53
`define TL_UT_ACTION_CODE 8'h54
`define TL_UNIT_CODE 8'hC8

// fields of the fault action byte
`define TL_RESP_MSB 7
`define TL_RESP_LSB 6
`define TL_RETRY_MSB 5
`define TL_RETRY_LSB 3
`define TL_DELAY_MSB 2
`define TL_DELAY_LSB 0

// response codes
`define TL_RESP_IGNORE 2'h0
`define TL_RESP_DELAY 2'h1
`define TL_RESP_RETRY 2'h2
`define TL_RESP_LATCH 2'h3

// retry field codes
`define TL_RETRY_NONE 3'h0
`define TL_RETRY_ENDLESS 3'h7

// reset values
`define TL_OT_WARN_RST 16'h0000
`define TL_UT_WARN_RST 16'h0000
`define TL_UT_FAULT_RST 16'h0000
`define TL_UT_ACTION_RST 8'hC0
`define TL_UNIT_RST 16'h03E8

// fractional bits of the internal fixed-point temperature
`define TL_FIX_FRAC 16

`endif

// ---- temp_limit_pkg.sv ----
package temp_limit_pkg;

  // one command from the bus engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  // answer to a command
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] rdata;
  } cmd_rsp_t;

  // fault response sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_DELAY,
    ST_WAIT,
    ST_ATTEMPT,
    ST_LATCHED
  } resp_state_t;

endpackage : temp_limit_pkg

// ---- delay_timer.sv ----
`timescale 1ns/1ps
module delay_timer #(
  parameter int UNIT_W = 16,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] exp_sel,
  input wire logic [UNIT_W-1:0] unit_cycles,
  // status
  output logic done
);

  typedef struct packed {
    logic run;
    logic done;
    logic [UNIT_W-1:0] pre;
    logic [CNT_W-1:0] left;
  } tmr_st_t;

  tmr_st_t q, d;
  logic [UNIT_W-1:0] unit_m1;

  // a zero unit length counts as one cycle
  assign unit_m1 = (unit_cycles == '0) ? '0 : unit_cycles - UNIT_W'(1);

  // prescaler over one unit, then 2^n units
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start) begin
      d.run = 1'b1;
      d.pre = unit_m1;
      d.left = CNT_W'((1 << exp_sel) - 1);
    end else if (stop) begin
      d.run = 1'b0;
    end else if (q.run) begin
      if (q.pre == '0) begin
        d.pre = unit_m1;
        if (q.left == '0) begin
          d.run = 1'b0;
          d.done = 1'b1;
        end else begin
          d.left = q.left - CNT_W'(1);
        end
      end else begin
        d.pre = q.pre - UNIT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule : delay_timer

// ---- temp_limit_fault_response.sv ----
// Functional notes
// - hold over-temperature warning limit at 0x51
// - hold under-temperature warning limit at 0x52
// - hold under-temperature fault limit at 0x53
// - code 00: keep regulating through fault
// - code 01: run for delay, then retry
// - code 10: disable at once, then retry
// - code 11: disable until fault cleared
// - clear, command, reset or off-on clears fault
// - retry 000: no restart, stay off
// - retry 1..6: that many attempts, then off
// - attempts spaced start to start by delay
// - retry 111: retry until commanded off
// - delay field n means 2^n units
// - delay unit length from register 0xC8
`timescale 1ns/1ps
`include "temp_limit_regs.svh"
module temp_limit_fault_response
  import temp_limit_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command port from the bus engine
  input wire cmd_req_t cmd,
  output cmd_rsp_t rsp,
  // temperature sample, linear format
  input wire logic [15:0] temp_code,
  input wire logic temp_valid,
  // output on/off commands and fault clearing
  input wire logic ctrl_on,
  input wire logic op_on,
  input wire logic clear_faults,
  input wire logic status_clr,
  // power stage and status
  output logic output_en,
  output logic ut_fault_flag,
  output logic ut_warn_flag,
  output logic ot_warn_flag,
  output logic [2:0] retry_count
);

  typedef struct packed {
    resp_state_t fsm;
    logic [15:0] ot_warn;
    logic [15:0] ut_warn;
    logic [15:0] ut_fault;
    logic [7:0] action;
    logic [UNIT_W-1:0] unit;
    cmd_rsp_t rsp;
    logic out_en;
    logic fault_lvl;
    logic otw_lvl;
    logic utw_lvl;
    logic fault_flag;
    logic otw_flag;
    logic utw_flag;
    logic [2:0] tries;
  } st_t;

  st_t q, d;
  logic tmr_start;
  logic tmr_stop;
  logic tmr_done;
  logic run_req;
  logic clr;
  logic do_shut;
  logic [1:0] resp_mode;
  logic [2:0] retries;
  logic [2:0] delay_sel;
  logic signed [47:0] t_fix;

  // linear format to signed fixed point with fixed fraction bits
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
    logic signed [10:0] m;
    logic [4:0] sh;
    logic signed [47:0] mx;
    m = v[10:0];
    sh = {~v[15], v[14:11]};
    mx = 48'(m);
    lin_to_fix = mx <<< sh;
  endfunction : lin_to_fix

  // action byte fields
  assign resp_mode = q.action[`TL_RESP_MSB:`TL_RESP_LSB];
  assign retries = q.action[`TL_RETRY_MSB:`TL_RETRY_LSB];
  assign delay_sel = q.action[`TL_DELAY_MSB:`TL_DELAY_LSB];
  assign run_req = ctrl_on & op_on;
  assign clr = clear_faults | status_clr;
  assign t_fix = lin_to_fix(temp_code);

  delay_timer #(
    .UNIT_W(UNIT_W),
    .CNT_W(8)
  ) u_timer (
    .clk(clk),
    .rstn(rstn),
    .start(tmr_start),
    .stop(tmr_stop),
    .exp_sel(delay_sel),
    .unit_cycles(q.unit),
    .done(tmr_done)
  );

  always_comb begin
    d = q;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    do_shut = 1'b0;

    // command decode and one-cycle answer
    d.rsp.valid = cmd.valid;
    d.rsp.err = 1'b0;
    d.rsp.rdata = 16'h0000;
    if (cmd.valid) begin
      unique case (cmd.code)
        `TL_OT_WARN_CODE: begin
          d.rsp.rdata = q.ot_warn;
          if (cmd.write) d.ot_warn = cmd.wdata;
        end
        `TL_UT_WARN_CODE: begin
          d.rsp.rdata = q.ut_warn;
          if (cmd.write) d.ut_warn = cmd.wdata;
        end
        `TL_UT_FAULT_CODE: begin
          d.rsp.rdata = q.ut_fault;
          if (cmd.write) d.ut_fault = cmd.wdata;
        end
        `TL_UT_ACTION_CODE: begin
          d.rsp.rdata = {8'h00, q.action};
          if (cmd.write) d.action = cmd.wdata[7:0];
        end
        `TL_UNIT_CODE: begin
          d.rsp.rdata = 16'(q.unit);
          if (cmd.write) d.unit = UNIT_W'(cmd.wdata);
        end
        default: begin
          d.rsp.err = 1'b1;
        end
      endcase
    end

    if (temp_valid) begin
      d.otw_lvl = t_fix > lin_to_fix(q.ot_warn);
      d.utw_lvl = t_fix < lin_to_fix(q.ut_warn);
      d.fault_lvl = t_fix < lin_to_fix(q.ut_fault);
    end

    // sticky flags, set wins over clear
    d.fault_flag = q.fault_lvl | (q.fault_flag & ~clr & run_req);
    d.otw_flag = q.otw_lvl | (q.otw_flag & ~clr);
    d.utw_flag = q.utw_lvl | (q.utw_flag & ~clr);

    if (!run_req) begin
      d.fsm = ST_IDLE;
      d.out_en = 1'b0;
      d.tries = 3'h0;
      tmr_stop = 1'b1;
    end else begin
      unique case (q.fsm)
        ST_IDLE: begin
          d.fsm = ST_RUN;
          d.out_en = 1'b1;
        end
        ST_RUN: begin
          if (q.fault_lvl) begin
            unique case (resp_mode)
              `TL_RESP_IGNORE: d.fsm = ST_RUN;
              `TL_RESP_DELAY: begin
                d.fsm = ST_DELAY;
                tmr_start = 1'b1;
              end
              `TL_RESP_RETRY: do_shut = 1'b1;
              `TL_RESP_LATCH: begin
                d.fsm = ST_LATCHED;
                d.out_en = 1'b0;
              end
            endcase
          end
        end
        ST_DELAY: begin
          if (!q.fault_lvl) begin
            d.fsm = ST_RUN;
            tmr_stop = 1'b1;
          end else if (tmr_done) begin
            do_shut = 1'b1;
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            if (retries == `TL_RETRY_ENDLESS || q.tries < retries) begin
              d.tries = (q.tries == 3'h7) ? q.tries : q.tries + 3'h1;
              d.out_en = 1'b1;
              d.fsm = ST_ATTEMPT;
              tmr_start = 1'b1;
            end else begin
              d.fsm = ST_LATCHED;
            end
          end
        end
        ST_ATTEMPT: begin
          if (q.fault_lvl) begin
            // failed attempt, timer keeps running
            d.out_en = 1'b0;
            d.fsm = ST_WAIT;
          end else if (tmr_done) begin
            d.fsm = ST_RUN;
            d.tries = 3'h0;
          end
        end
        ST_LATCHED: begin
          if (clr) begin
            d.fsm = ST_RUN;
            d.out_en = 1'b1;
            d.tries = 3'h0;
          end
        end
        // illegal state codes fall back to idle
        default: begin
          d.fsm = ST_IDLE;
          d.out_en = 1'b0;
        end
      endcase
    end

    // shutdown with retry decision
    if (do_shut) begin
      d.out_en = 1'b0;
      d.tries = 3'h0;
      if (retries == `TL_RETRY_NONE) begin
        d.fsm = ST_LATCHED;
      end else begin
        d.fsm = ST_WAIT;
        tmr_start = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.ot_warn <= `TL_OT_WARN_RST;
      q.ut_warn <= `TL_UT_WARN_RST;
      q.ut_fault <= `TL_UT_FAULT_RST;
      q.action <= `TL_UT_ACTION_RST;
      q.unit <= UNIT_W'(`TL_UNIT_RST);
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign rsp = q.rsp;
  assign output_en = q.out_en;
  assign ut_fault_flag = q.fault_flag;
  assign ut_warn_flag = q.utw_flag;
  assign ot_warn_flag = q.otw_flag;
  assign retry_count = q.tries;

endmodule : temp_limit_fault_response

// ---- temp_limit_fault_response_properties.sv ----
`timescale 1ns/1ps
module temp_limit_checker
  import temp_limit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command port
  input wire cmd_req_t cmd,
  input wire cmd_rsp_t rsp,
  // temperature and controls
  input wire logic [15:0] temp_code,
  input wire logic temp_valid,
  input wire logic ctrl_on,
  input wire logic op_on,
  input wire logic clear_faults,
  input wire logic status_clr,
  // outputs
  input wire logic output_en,
  input wire logic ut_fault_flag,
  input wire logic ut_warn_flag,
  input wire logic ot_warn_flag,
  input wire logic [2:0] retry_count
);
  logic [7:0] act_q;
  logic on_w;
  logic known_w;
  // output wanted and mapped code
  assign on_w = ctrl_on & op_on;
  assign known_w = cmd.code inside {8'h51, 8'h52, 8'h53, 8'h54, 8'hC8};
  // shadow of the fault action byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_q <= 8'hC0;
    end else if (cmd.valid && cmd.write && cmd.code == 8'h54) begin
      act_q <= cmd.wdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rsp_one_later: assert property (cmd.valid |=> rsp.valid)
    else $error("no response one cycle after command");
  a_err_unmapped: assert property (cmd.valid && !known_w |=> rsp.err && rsp.rdata == 16'h0000)
    else $error("unmapped code not refused");
  a_ignore_keeps_on: assert property (act_q[7:6] == 2'h0 && output_en && on_w |=> output_en)
    else $error("output dropped in ignore mode");
  a_delay_holds: assert property (
    act_q[7:6] == 2'h1 && $rose(ut_fault_flag) && output_en && on_w |=> output_en)
    else $error("output dropped before delay ran out");
  a_shutdown_fast: assert property (act_q[7] && $rose(ut_fault_flag) |=> !output_en)
    else $error("output not disabled on fault");
  a_latch_stays: assert property (
    act_q[7:6] == 2'h3 && !output_en && ut_fault_flag && on_w
    && !clear_faults && !status_clr |=> !output_en)
    else $error("latched output came back without clear");
  a_clear_restores: assert property (
    act_q[7:6] == 2'h3 && !output_en && ut_fault_flag && on_w
    && clear_faults |-> ##[1:3] output_en)
    else $error("clear did not restore output");
  a_off_cmd: assert property (!on_w [*2] |-> !output_en)
    else $error("output on while commanded off");
endmodule : temp_limit_checker

bind temp_limit_fault_response temp_limit_checker u_temp_limit_checker (.clk, .rstn, .cmd, .rsp,
  .temp_code, .temp_valid, .ctrl_on, .op_on, .clear_faults, .status_clr, .output_en,
  .ut_fault_flag, .ut_warn_flag, .ot_warn_flag, .retry_count);

// ---- temp_host_model.sv ----
`timescale 1ns/1ps
module temp_host_model
  import temp_limit_pkg::*;
(
  // clock
  input wire logic clk,
  // command port
  output cmd_req_t cmd
);
  initial cmd = '0;
  // one command pulse taken at one edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    @(posedge clk);
    cmd <= '{1'b1, wr, code, wd};
    @(posedge clk);
    cmd <= '0;
  endtask : xfer
endmodule : temp_host_model

// ---- temp_limit_fault_response_test.sv ----
`timescale 1ns/1ps
module temp_limit_fault_response_test;
  import temp_limit_pkg::*;
  logic clk, rstn, temp_valid, ctrl_on, op_on, clear_faults, status_clr;
  logic output_en, ut_fault_flag, ut_warn_flag, ot_warn_flag;
  logic [15:0] temp_code;
  logic [15:0] ot_d;
  logic [2:0] retry_count;
  logic [17:0] exp_e;
  logic [17:0] exp_q[$];
  logic [31:0] lfsr_q = 32'h087f_fd35;
  logic [7:0] act_t [4] = '{8'h00, 8'h43, 8'h88, 8'hC0};
  logic [3:0] late_t [4] = '{4'h1, 4'h0, 4'h2, 4'h0};
  cmd_req_t cmd;
  cmd_rsp_t rsp;
  int failures = 0;
  int checked = 0;

  temp_limit_fault_response u_temp_limit_fault_response (.clk, .rstn, .cmd, .rsp, .temp_code,
    .temp_valid, .ctrl_on, .op_on, .clear_faults, .status_clr, .output_en, .ut_fault_flag,
    .ut_warn_flag, .ot_warn_flag, .retry_count);
  temp_host_model u_temp_host_model (.clk, .cmd);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : check

  // note {care, err, rdata} then issue the command
  task automatic reg_op(input logic wr, input logic [7:0] code, input logic [15:0] d,
    input logic [17:0] e);
    exp_q.push_back(e);
    u_temp_host_model.xfer(wr, code, d);
  endtask : reg_op

  task automatic temp(input logic [15:0] t);
    @(posedge clk);
    temp_code <= t;
    temp_valid <= 1'b1;
    @(posedge clk);
    temp_valid <= 1'b0;
  endtask : temp

  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // response compare against the oldest note
  always @(posedge clk) begin
    if (rsp.valid === 1'b1 && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      check("rsp_err", {15'h0000, exp_e[16]}, {15'h0000, rsp.err});
      if (exp_e[17]) check("rsp_rdata", exp_e[15:0], rsp.rdata);
    end
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    temp_code = 16'h0014;
    temp_valid = 1'b0;
    ctrl_on = 1'b1;
    op_on = 1'b1;
    clear_faults = 1'b0;
    status_clr = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // register defaults, limits and refusal
    reg_op(1'b0, 8'h54, 16'h0000, 18'h2_00C0);
    reg_op(1'b0, 8'h51, 16'h0000, 18'h2_0000);
    lfsr_q = lfsr(lfsr_q);
    ot_d = {11'h001, lfsr_q[4:0]};
    reg_op(1'b1, 8'h51, ot_d, 18'h0_0000);
    reg_op(1'b0, 8'h51, 16'h0000, {2'b10, ot_d});
    reg_op(1'b1, 8'h52, 16'h000A, 18'h0_0000);
    reg_op(1'b0, 8'h52, 16'h0000, 18'h2_000A);
    reg_op(1'b1, 8'h53, 16'h0005, 18'h0_0000);
    reg_op(1'b0, 8'h53, 16'h0000, 18'h2_0005);
    reg_op(1'b1, 8'hC8, 16'h0001, 18'h0_0000);
    reg_op(1'b0, 8'h60, 16'h0000, 18'h3_0000);
    $display("registers done");
    // each response mode against a held fault
    for (int i = 0; i < 4; i++) begin
      reg_op(1'b1, 8'h54, {8'h00, act_t[i]}, 18'h0_0000);
      temp(16'h0002);
      repeat (30) @(posedge clk);
      check("count_en", {12'h000, late_t[i]}, {12'h000, retry_count, output_en});
      check("flags", 16'h0006, {13'h0000, ut_fault_flag, ut_warn_flag, ot_warn_flag});
      temp(16'h0014);
      // clear by command, status bit, or two cycles off on either control
      clear_faults <= (i == 3);
      status_clr <= (i == 1);
      ctrl_on <= (i != 2);
      op_on <= (i != 0);
      @(posedge clk);
      clear_faults <= 1'b0;
      status_clr <= 1'b0;
      @(posedge clk);
      ctrl_on <= 1'b1;
      op_on <= 1'b1;
      repeat (5) @(posedge clk);
      check("cleared", 16'h0001, {14'h0000, ut_fault_flag, output_en});
      $display("mode test %0d done", i);
    end
    // reset in mid-run clears a latched fault and restores the registers
    reg_op(1'b1, 8'h54, 16'h00C0, 18'h0_0000);
    temp(16'h0002);
    repeat (10) @(posedge clk);
    check("latched", 16'h0002, {14'h0000, ut_fault_flag, output_en});
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check("after_reset", 16'h0001, {14'h0000, ut_fault_flag, output_en});
    temp(16'h0014);
    repeat (2) @(posedge clk);
    check("ot_flag", 16'h0001, {13'h0000, ut_fault_flag, ut_warn_flag, ot_warn_flag});
    reg_op(1'b0, 8'h53, 16'h0000, 18'h2_0000);
    repeat (2) @(posedge clk);
    $display("reset test done");
    check("notes_left", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule : temp_limit_fault_response_test
